//--- pkg/xdata_route_pkg.sv
// Constants and carrier types for the external-data access router
package xdata_route_pkg;
	localparam logic [7:0] PORT_LATCH_RESET = 8'h00_FF;
	localparam logic [7:0] PAGE_REG_RESET = 8'h00_00;
	localparam logic [7:0] PAGE_SELECT_RESET = 8'h00_F8;
	localparam logic RAM_DISABLE_RESET = 1'b1;
	localparam logic STROBE_VIS_RESET = 1'b0;
	localparam logic [1:0] ROLE_IO = 2'h0;
	localparam logic [1:0] STROBE_N_IDLE = 2'h3;
	localparam logic [15:0] RAM_ADDR_RESET = 16'h0000;
	localparam logic [7:0] RAM_WDATA_RESET = 8'h00;

	// One external-data move request from the core
	typedef struct packed {
		logic valid;
		logic write;
		logic use_data_pointer;
		logic [15:0] data_pointer;
		logic [7:0] indirect_addr;
		logic [7:0] wdata;
	} access_req_s;

	// Routing outcome of one move
	typedef struct packed {
		logic low_bus;
		logic high_bus;
		logic rd_strobe;
		logic wr_strobe;
		logic use_onchip;
	} route_s;
endpackage

//--- design/xdata_access_router.sv
// Router that steers external-data moves to on-chip RAM or the multiplexed bus
`timescale 1ns/1ps
module xdata_access_router (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Core side
	input wire xdata_route_pkg::access_req_s req_i,
	input wire logic external_access_pin_i,
	input wire logic ram_disable_clear_i,
	input wire logic strobe_visibility_wr_i,
	input wire logic strobe_visibility_wdata_i,
	input wire logic page_select_wr_i,
	input wire logic [7:0] page_select_wdata_i,
	input wire logic page_reg_wr_i,
	input wire logic high_latch_wr_i,
	input wire logic low_latch_wr_i,
	input wire logic [7:0] latch_wdata_i,
	// Pins
	output logic [7:0] low_address_data_port_o,
	output logic [7:0] high_address_port_o,
	output logic low_port_bus_o,
	output logic high_port_bus_o,
	output logic rd_strobe_n_o,
	output logic wr_strobe_n_o,
	// On-chip RAM port
	output logic onchip_ram_sel_o,
	output logic onchip_ram_we_o,
	output logic [15:0] onchip_ram_addr_o,
	output logic [7:0] onchip_ram_wdata_o,
	// Status
	output logic onchip_ram_disable_bit_o,
	output logic strobe_visibility_bit_o,
	output logic [7:0] indirect_page_register_o
);
	import xdata_route_pkg::*;

	logic [7:0] low_latch_reg;
	logic [7:0] high_latch_reg;
	logic [7:0] page_reg;
	logic [7:0] page_select_reg;
	logic ram_disable_reg;
	logic strobe_vis_reg;

	wire logic [7:0] upper_byte;
	wire logic in_range;
	wire logic onchip;
	wire logic [15:0] bus_addr;
	wire logic [15:0] onchip_addr;
	route_s route;

	// Indirect moves take their upper byte from the page register for matching
	assign upper_byte = req_i.use_data_pointer ? req_i.data_pointer[15:8] : page_reg;
	assign in_range = (upper_byte == page_select_reg);
	assign onchip = in_range && !ram_disable_reg;

	// Off-page indirect address uses the high port latch, not the page register
	assign bus_addr = req_i.use_data_pointer ? req_i.data_pointer
		: {high_latch_reg, req_i.indirect_addr};
	assign onchip_addr = {upper_byte, bus_addr[7:0]};

	// Pin high blocks the write-data view only for control bits 00
	wire logic onchip_low_bus = strobe_vis_reg || !external_access_pin_i;
	assign route.use_onchip = onchip;
	assign route.low_bus = !onchip || (onchip_low_bus && req_i.write) || strobe_vis_reg;
	assign route.high_bus = req_i.use_data_pointer ? route.low_bus : 1'b0;
	assign route.rd_strobe = !req_i.write && (!onchip || strobe_vis_reg);
	assign route.wr_strobe = req_i.write && (!onchip || strobe_vis_reg);

	// With strobes visible on-chip, reads show the low address and writes show data on the low port
	wire logic show_data = !onchip || req_i.write;

	// Next pin values
	wire logic [7:0] low_bus_value;
	wire logic [7:0] low_port_next;
	wire logic [7:0] high_port_next;
	wire logic low_bus_next;
	wire logic high_bus_next;
	wire logic rd_strobe_n_next;
	wire logic wr_strobe_n_next;
	wire logic ram_sel_next;
	wire logic ram_we_next;
	wire logic [15:0] ram_addr_next;
	wire logic [7:0] ram_wdata_next;

	// Bus role carries data on writes, low address otherwise
	assign low_bus_value = (req_i.write && show_data) ? req_i.wdata : bus_addr[7:0];
	// Without a move the pins fall back to latch-controlled I/O
	assign low_bus_next = req_i.valid && route.low_bus;
	assign high_bus_next = req_i.valid && route.high_bus;
	assign low_port_next = low_bus_next ? low_bus_value : low_latch_reg;
	assign high_port_next = high_bus_next ? bus_addr[15:8] : high_latch_reg;
	assign rd_strobe_n_next = !(req_i.valid && route.rd_strobe);
	assign wr_strobe_n_next = !(req_i.valid && route.wr_strobe);
	assign ram_sel_next = req_i.valid && route.use_onchip;
	assign ram_we_next = ram_sel_next && req_i.write;
	// Address and data hold between moves so the RAM port stays quiet
	assign ram_addr_next = req_i.valid ? onchip_addr : onchip_ram_addr_o;
	assign ram_wdata_next = req_i.valid ? req_i.wdata : onchip_ram_wdata_o;

	// Latch writes steer moves from the next edge on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_latch_reg <= PORT_LATCH_RESET;
		end else if (low_latch_wr_i) begin
			low_latch_reg <= latch_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_latch_reg <= PORT_LATCH_RESET;
		end else if (high_latch_wr_i) begin
			high_latch_reg <= latch_wdata_i;
		end
	end

	// Port write wins the page register so both hold the same byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_reg <= PAGE_REG_RESET;
		end else if (high_latch_wr_i || page_reg_wr_i) begin
			page_reg <= latch_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_select_reg <= PAGE_SELECT_RESET;
		end else if (page_select_wr_i) begin
			page_select_reg <= page_select_wdata_i;
		end
	end

	// Clear only; nothing but reset sets it again
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram_disable_reg <= RAM_DISABLE_RESET;
		end else if (ram_disable_clear_i) begin
			ram_disable_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_vis_reg <= STROBE_VIS_RESET;
		end else if (strobe_visibility_wr_i) begin
			strobe_vis_reg <= strobe_visibility_wdata_i;
		end
	end

	// Pin values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_address_data_port_o <= PORT_LATCH_RESET;
			high_address_port_o <= PORT_LATCH_RESET;
		end else begin
			low_address_data_port_o <= low_port_next;
			high_address_port_o <= high_port_next;
		end
	end

	// Pin roles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{low_port_bus_o, high_port_bus_o} <= ROLE_IO;
		end else begin
			low_port_bus_o <= low_bus_next;
			high_port_bus_o <= high_bus_next;
		end
	end

	// Strobes are active low and last one cycle per move
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{rd_strobe_n_o, wr_strobe_n_o} <= STROBE_N_IDLE;
		end else begin
			rd_strobe_n_o <= rd_strobe_n_next;
			wr_strobe_n_o <= wr_strobe_n_next;
		end
	end

	// On-chip RAM select and write enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			onchip_ram_sel_o <= 1'b0;
			onchip_ram_we_o <= 1'b0;
		end else begin
			onchip_ram_sel_o <= ram_sel_next;
			onchip_ram_we_o <= ram_we_next;
		end
	end

	// On-chip RAM address and write data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			onchip_ram_addr_o <= RAM_ADDR_RESET;
			onchip_ram_wdata_o <= RAM_WDATA_RESET;
		end else begin
			onchip_ram_addr_o <= ram_addr_next;
			onchip_ram_wdata_o <= ram_wdata_next;
		end
	end

	// Status view, one cycle behind the state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			onchip_ram_disable_bit_o <= RAM_DISABLE_RESET;
			strobe_visibility_bit_o <= STROBE_VIS_RESET;
			indirect_page_register_o <= PAGE_REG_RESET;
		end else begin
			onchip_ram_disable_bit_o <= ram_disable_reg;
			strobe_visibility_bit_o <= strobe_vis_reg;
			indirect_page_register_o <= page_reg;
		end
	end
endmodule

//--- tb/xdata_route_asserts.sv
// Assertion checker for the external-data access router
`timescale 1ns/1ps
module xdata_route_asserts (
	input wire logic clk_i, rst_i, ram_disable_clear_i, page_reg_wr_i, high_latch_wr_i,
	input wire xdata_route_pkg::access_req_s req_i,
	input wire logic [7:0] latch_wdata_i, high_address_port_o, indirect_page_register_o,
	input wire logic low_port_bus_o, high_port_bus_o, rd_strobe_n_o, wr_strobe_n_o,
	input wire logic onchip_ram_sel_o, onchip_ram_we_o, onchip_ram_disable_bit_o
);
	import xdata_route_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire v = req_i.valid;
	a_idle_io: assert property (!v |=> rd_strobe_n_o && wr_strobe_n_o && !low_port_bus_o
		&& !high_port_bus_o && !onchip_ram_sel_o) else $error("idle cycle kept bus role");
	a_strobe_excl: assert property (rd_strobe_n_o || wr_strobe_n_o)
		else $error("both strobes low");
	a_read_nowr: assert property (v && !req_i.write |=> wr_strobe_n_o && !onchip_ram_we_o)
		else $error("read move wrote");
	a_disabled_ext: assert property (onchip_ram_disable_bit_o && !$past(ram_disable_clear_i)
		&& v && req_i.use_data_pointer |=> low_port_bus_o && high_port_bus_o
		&& !onchip_ram_sel_o
		&& (rd_strobe_n_o != wr_strobe_n_o)) else $error("disabled move not external");
	a_ind_high_io: assert property (v && !req_i.use_data_pointer |=> !high_port_bus_o)
		else $error("indirect move drove high port");
	a_pointer_addr: assert property (v && req_i.use_data_pointer |=>
		!high_port_bus_o || high_address_port_o == $past(req_i.data_pointer[15:8]))
		else $error("wrong high address");
	a_clear_sticky: assert property (!onchip_ram_disable_bit_o |=> !onchip_ram_disable_bit_o)
		else $error("disable bit set again");
	a_page_follow: assert property (high_latch_wr_i && !page_reg_wr_i ##1
		!page_reg_wr_i && !high_latch_wr_i |=> indirect_page_register_o == $past(latch_wdata_i, 2))
		else $error("page register missed latch write");
	c_onchip: cover property (v ##1 onchip_ram_sel_o);
	c_ext_wr: cover property (v ##1 !wr_strobe_n_o);
	c_clear: cover property ($fell(onchip_ram_disable_bit_o));
endmodule
bind xdata_access_router xdata_route_asserts xdata_route_asserts_inst (.*);

//--- tb/xdata_ext_mem_model.sv
// External data memory seen on the multiplexed bus
`timescale 1ns/1ps
module xdata_ext_mem_model (
	input wire logic clk_i, wr_n_i, low_bus_i,
	input wire logic [7:0] bus_i,
	output logic [7:0] last_wdata_o
);
	// Low address byte is not visible in this single-cycle view, data only
	always @(posedge clk_i) if (!wr_n_i && low_bus_i) last_wdata_o <= bus_i;
endmodule

//--- tb/xdata_access_router_tb.sv
// Directed testbench for the external-data access router
`timescale 1ns/1ps
module xdata_access_router_tb;
	import xdata_route_pkg::*;
	logic clk_i = 0, rst_i = 1, pin = 0, clr = 0, vwr = 0, vd = 1, psw = 0, pgw = 0, hw = 0, lw = 0;
	logic [7:0] ps = 8'h00_F8, ld = 0, lp, hp, ip, mw;
	logic lb, hb, rn, wn, sel, dis, we, vis;
	logic [15:0] ra;
	logic [7:0] rw;
	access_req_s req_i = '0;
	int mismatches = 0, check_count = 0;
	xdata_access_router xdata_access_router_inst (.clk_i, .rst_i, .req_i,
		.external_access_pin_i(pin), .ram_disable_clear_i(clr), .strobe_visibility_wr_i(vwr),
		.strobe_visibility_wdata_i(vd), .page_select_wr_i(psw), .page_select_wdata_i(ps),
		.page_reg_wr_i(pgw), .high_latch_wr_i(hw), .low_latch_wr_i(lw), .latch_wdata_i(ld),
		.low_address_data_port_o(lp), .high_address_port_o(hp), .low_port_bus_o(lb),
		.high_port_bus_o(hb), .rd_strobe_n_o(rn), .wr_strobe_n_o(wn), .onchip_ram_sel_o(sel),
		.onchip_ram_we_o(we), .onchip_ram_addr_o(ra), .onchip_ram_wdata_o(rw),
		.onchip_ram_disable_bit_o(dis), .strobe_visibility_bit_o(vis),
		.indirect_page_register_o(ip));
	xdata_ext_mem_model xdata_ext_mem_model_inst (.clk_i, .wr_n_i(wn), .low_bus_i(lb),
		.bus_i(lp), .last_wdata_o(mw));
	initial forever #5 clk_i = ~clk_i;
	task automatic ck(logic [15:0] g, e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	task automatic mv(logic w, d, logic [15:0] a, logic [7:0] x, logic [4:0] e, logic [7:0] h);
		@(negedge clk_i);
		req_i <= {1'b1, w, d, a, a[7:0], x};
		@(negedge clk_i);
		req_i.valid <= 0;
		ck({lb, hb, rn, wn, sel, hp}, {e, h});
	endtask
	task automatic ctl(logic [5:0] s, logic [7:0] v);
		@(negedge clk_i);
		{psw, clr, vwr, pgw, hw, lw} <= s;
		ld <= v;
		ps <= v;
		@(negedge clk_i);
		{psw, clr, vwr, pgw, hw, lw} <= '0;
	endtask
	task complete_run;
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk_i);
		rst_i <= 0;
		ck(dis, 1);
		mv(1, 1, 16'h1234, 8'h5A, 5'b11100, 8'h12);
		ck(lp, 8'h5A);
		@(negedge clk_i);
		ck(mw, 8'h5A);
		mv(0, 1, 16'hF800, 0, 5'b11010, 8'hF8);
		mv(0, 0, 16'h0030, 0, 5'b10010, 8'hFF);
		ck(lp, 8'h30);
		ctl(6'b000010, 8'hF8);
		mv(0, 0, 16'h0030, 0, 5'b10010, 8'hF8);
		ck(ip, 8'hF8);
		ctl(6'b010011, 8'hA5);
		ctl(6'b000100, 8'hF8);
		ck(dis, 0);
		mv(1, 0, 16'h0030, 8'h11, 5'b10111, 8'hA5);
		ck({we, rw}, 9'h111);
		ck(ra, 16'hF830);
		pin <= 1;
		mv(0, 1, 16'hF810, 0, 5'b00111, 8'hA5);
		mv(1, 1, 16'hF810, 8'h22, 5'b00111, 8'hA5);
		ck(lp, 8'hA5);
		pin <= 0;
		mv(1, 1, 16'hF810, 8'h33, 5'b11111, 8'hF8);
		ck(lp, 8'h33);
		ctl(6'b001000, 0);
		mv(1, 1, 16'hF820, 8'h44, 5'b11101, 8'hF8);
		ck(vis, 1);
		mv(1, 0, 16'h0040, 8'h55, 5'b10101, 8'hA5);
		ck(lp, 8'h55);
		mv(1, 1, 16'h1234, 8'h66, 5'b11100, 8'h12);
		@(negedge clk_i);
		ck(mw, 8'h66);
		ctl(6'b100000, 8'h12);
		mv(0, 1, 16'h1234, 0, 5'b11011, 8'h12);
		ck(lp, 8'h34);
		vd <= 0;
		ctl(6'b001000, 0);
		mv(0, 1, 16'h1234, 0, 5'b00111, 8'hA5);
		ck(vis, 0);
		rst_i <= 1;
		repeat (2) @(negedge clk_i);
		rst_i <= 0;
		ck(dis, 1);
		mv(1, 1, 16'hF800, 8'h77, 5'b11100, 8'hF8);
		@(negedge clk_i);
		ck(mw, 8'h77);
		complete_run;
	end
endmodule
